// ### shared/fci_defines.svh
// Constants shared by both ends of the coprocessor port.
// Assumes inclusion by bare name from files that use the port.
`ifndef FCI_DEFINES_SVH
`define FCI_DEFINES_SVH
`define FCI_CC_W        2
`define FCI_INSN_W      32
`define FCI_DATA_W      32
`define FCI_QUEUE_DEPTH 4
`define FCI_QPTR_W      2
`define FCI_QCNT_W      3
`define FCI_CMP_CYCLES  3'h3
`define FCI_CNT_W       3
`endif

// ### shared/fci_pkg.sv
// Types shared by both ends of the coprocessor port.
// Assumes fci_defines.svh is on the include path.
package fci_pkg;
   typedef enum logic [2:0] {
      FCI_OP_NONE   = 3'h0,
      FCI_OP_OPERATE = 3'h1,
      FCI_OP_BRANCH = 3'h2,
      FCI_OP_LDST   = 3'h3,
      FCI_OP_COMPARE = 3'h4,
      FCI_OP_STSTATE = 3'h5
   } fci_op_t;
   typedef enum logic [1:0] {
      FCI_ST_RUN  = 2'h0,
      FCI_ST_TRAP = 2'h1,
      FCI_ST_ACK  = 2'h2
   } fci_state_t;
endpackage : fci_pkg

// ### shared/fci_if.sv
// Pin group joining the integer unit to the floating-point unit and coprocessor.
// Assumes both ends run on one ref_clk; the bench instantiates it.
`timescale 1ns/100ps
`include "fci_defines.svh"
interface fci_if;
   logic [`FCI_CC_W-1:0]   float_cond_codes;
   logic                   float_codes_valid;
   logic                   float_exception;
   logic                   float_hold;
   logic                   float_issue_buf_one;
   logic                   float_issue_buf_two;
   logic                   float_unit_present_n;
   logic                   float_exception_ack;
   logic [`FCI_CC_W-1:0]   coproc_cond_codes;
   logic                   coproc_codes_valid;
   logic                   coproc_exception;
   logic                   coproc_hold;
   logic                   coproc_issue_buf_one;
   logic                   coproc_issue_buf_two;
   logic                   coproc_present_n;
   logic                   coproc_exception_ack;
   logic                   flush;
   logic                   fetch_strobe;
   logic [`FCI_DATA_W-1:0] data_bus;
   modport iu (
      input  float_cond_codes, float_codes_valid, float_exception, float_hold, float_unit_present_n,
      input  coproc_cond_codes, coproc_codes_valid, coproc_exception, coproc_hold, coproc_present_n,
      output float_issue_buf_one, float_issue_buf_two, float_exception_ack,
      output coproc_issue_buf_one, coproc_issue_buf_two, coproc_exception_ack,
      output flush, fetch_strobe, data_bus
   );
   modport fpu (
      output float_cond_codes, float_codes_valid, float_exception, float_hold, float_unit_present_n,
      input  float_issue_buf_one, float_issue_buf_two, float_exception_ack,
      input  coproc_codes_valid, coproc_hold, flush, fetch_strobe, data_bus
   );
endinterface : fci_if

// ### rtl/fci_fpu_end.sv
// Floating-point unit end of the coprocessor port: two decode buffers, queue, hold,
// compare interlock and exception request.
// Assumes the integer-unit end on the same ref_clk; the exception source is a user input.
`timescale 1ns/100ps
`include "fci_defines.svh"
module fci_fpu_end (
   input  wire logic                ref_clk,
   input  wire logic                reset_n,
   input  wire logic                clk_en,
   fci_if.fpu                       port,
   input  wire logic                unit_fitted,
   input  wire logic                raise_exception,
   input  wire logic [`FCI_CC_W-1:0] compare_result,
   output logic                     queue_busy
);
   logic [`FCI_INSN_W-1:0] buf_one_reg, buf_two_reg;
   logic [`FCI_QCNT_W-1:0] qcount_reg;
   logic [`FCI_CNT_W-1:0]  cmp_cnt_reg;
   logic                   cmp_busy_reg, exc_reg, exc_pend_reg, hold_reg, ccv_reg;
   logic [`FCI_CC_W-1:0]   cc_reg;
   logic                   drain_reg, busy_reg;
   // Issue is ignored while flush or any hold is active, or either codes-valid is inactive.
   wire issue_ok  = !port.flush && !port.float_hold && !port.coproc_hold
                    && port.float_codes_valid && port.coproc_codes_valid;
   wire issue_one = port.float_issue_buf_one && issue_ok;
   wire issue_two = port.float_issue_buf_two && issue_ok;
   wire [`FCI_INSN_W-1:0] issued = issue_two ? buf_two_reg : buf_one_reg;
   wire [2:0] issued_op = issued[2:0];
   wire issued_valid = issue_one || issue_two;
   wire is_cmp = issued_valid && (issued_op == fci_pkg::FCI_OP_COMPARE);
   wire is_st  = issued_valid && (issued_op == fci_pkg::FCI_OP_STSTATE);
   wire is_opr = issued_valid && (issued_op == fci_pkg::FCI_OP_OPERATE);
   wire q_full = (qcount_reg == `FCI_QCNT_W'(`FCI_QUEUE_DEPTH));
   wire q_enter = is_opr || is_cmp;
   // Dependency stands for a compare still in flight when another operate or compare is decoded.
   wire hold_next = (is_st && qcount_reg != '0) || (q_enter && cmp_busy_reg) || (q_enter && q_full);
   wire exc_fire = raise_exception && !exc_reg;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         buf_one_reg  <= '0;
         buf_two_reg  <= '0;
      end else if (clk_en && port.fetch_strobe) begin
         buf_one_reg  <= port.data_bus;
         buf_two_reg  <= buf_one_reg;
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         hold_reg     <= 1'b0;
         exc_reg      <= 1'b0;
         exc_pend_reg <= 1'b0;
      end else if (clk_en) begin
         // A new exception while holding raises the request first, then drops the hold.
         if (exc_fire && hold_reg) exc_pend_reg <= 1'b1;
         if (exc_pend_reg) begin
            hold_reg     <= 1'b0;
            exc_pend_reg <= 1'b0;
         end else if (!exc_fire) begin
            hold_reg <= hold_next || (hold_reg && (cmp_busy_reg || q_full));
         end
         if (exc_fire) exc_reg <= 1'b1;
         else if (port.float_exception_ack) exc_reg <= 1'b0;
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         qcount_reg   <= '0;
         cmp_busy_reg <= 1'b0;
         cmp_cnt_reg  <= '0;
         ccv_reg      <= 1'b1;
         cc_reg       <= '0;
         drain_reg    <= 1'b0;
         busy_reg     <= 1'b0;
      end else if (clk_en) begin
         busy_reg <= qcount_reg != '0;
         if (port.flush) begin
            drain_reg <= exc_reg;
            if (exc_reg) qcount_reg <= '0;
         end else if (q_enter && !q_full) begin
            qcount_reg <= qcount_reg + `FCI_QCNT_W'(1);
         end else if (qcount_reg != '0 && !cmp_busy_reg) begin
            qcount_reg <= qcount_reg - `FCI_QCNT_W'(1);
         end
         if (is_cmp && !exc_reg && !raise_exception) begin
            ccv_reg      <= 1'b0;
            cmp_busy_reg <= 1'b1;
            cmp_cnt_reg  <= `FCI_CMP_CYCLES;
         end else if (cmp_busy_reg) begin
            if (cmp_cnt_reg == '0) begin
               cmp_busy_reg <= 1'b0;
               cc_reg       <= compare_result;
               ccv_reg      <= 1'b1;
            end else begin
               cmp_cnt_reg <= cmp_cnt_reg - `FCI_CNT_W'(1);
            end
         end
         if (drain_reg && qcount_reg == '0) drain_reg <= 1'b0;
      end
   end
   assign port.float_cond_codes     = cc_reg;
   assign port.float_codes_valid    = ccv_reg;
   assign port.float_exception      = exc_reg;
   assign port.float_hold           = hold_reg;
   assign port.float_unit_present_n = !unit_fitted;
   assign queue_busy                = busy_reg;
endmodule : fci_fpu_end

// ### rtl/fci_iu_end.sv
// Integer-unit end of the coprocessor port: issue strobes, freeze, trap, flush, acks.
// Assumes the attached units share ref_clk; every port input is still passed through two
// flip-flops because the pins come from separate chips.
`timescale 1ns/100ps
`include "fci_defines.svh"
module fci_iu_end (
   input  wire logic                   ref_clk,
   input  wire logic                   reset_n,
   input  wire logic                   clk_en,
   fci_if.iu                           port,
   input  wire logic                   fetch_req,
   input  wire logic [`FCI_DATA_W-1:0] fetch_word,
   input  wire logic                   decode_valid,
   input  wire logic                   decode_is_cop,
   input  wire logic                   decode_in_buf_two,
   input  wire fci_pkg::fci_op_t       decode_op,
   input  wire logic [`FCI_CC_W-1:0]   branch_cond,
   output logic                        frozen,
   output logic                        branch_taken,
   output logic                        trap_taken,
   output logic                        trap_disabled,
   output logic                        trap_exception
);
   // Pin inputs: index 0 tied low (float cc has its own flops), 1 float valid, 2 float exc, 3 float hold, 4 float present_n,
   // then the same five for the coprocessor at 5..9, with 5 tied low.
   localparam int NIN = 10;
   wire  [NIN-1:0] pin_raw = {port.coproc_present_n, port.coproc_hold, port.coproc_exception,
                             port.coproc_codes_valid, 1'b0,
                             port.float_unit_present_n, port.float_hold, port.float_exception,
                             port.float_codes_valid, 1'b0};
   logic [NIN-1:0] sync1_reg, sync2_reg;
   logic [`FCI_CC_W-1:0] fcc1_reg, fcc2_reg, ccc1_reg, ccc2_reg;
   genvar gi;
   generate
      for (gi = 0; gi < NIN; gi++) begin : g_sync
         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               sync1_reg[gi] <= (gi == 1 || gi == 6 || gi == 4 || gi == 9);
               sync2_reg[gi] <= (gi == 1 || gi == 6 || gi == 4 || gi == 9);
            end else if (clk_en) begin
               sync1_reg[gi] <= pin_raw[gi];
               sync2_reg[gi] <= sync1_reg[gi];
            end
         end
      end
   endgenerate
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         fcc1_reg <= '0;
         fcc2_reg <= '0;
         ccc1_reg <= '0;
         ccc2_reg <= '0;
      end else if (clk_en) begin
         fcc1_reg <= port.float_cond_codes;
         fcc2_reg <= fcc1_reg;
         ccc1_reg <= port.coproc_cond_codes;
         ccc2_reg <= ccc1_reg;
      end
   end
   wire f_valid = sync2_reg[1];
   wire f_exc   = sync2_reg[2];
   wire f_hold  = sync2_reg[3];
   wire f_abs   = sync2_reg[4];
   wire c_valid = sync2_reg[6];
   wire c_exc   = sync2_reg[7];
   wire c_hold  = sync2_reg[8];
   wire c_abs   = sync2_reg[9];
   // One freeze term from registered inputs only.
   wire freeze = f_hold || c_hold || !f_valid || !c_valid;
   function automatic logic unit_op(input fci_pkg::fci_op_t op);
      unit_op = (op == fci_pkg::FCI_OP_OPERATE) || (op == fci_pkg::FCI_OP_BRANCH) ||
                (op == fci_pkg::FCI_OP_LDST) || (op == fci_pkg::FCI_OP_COMPARE) ||
                (op == fci_pkg::FCI_OP_STSTATE);
   endfunction : unit_op
   logic trap_cycle_reg, ack_f_reg, ack_c_reg, flush_reg, fetch_reg;
   logic is1_f_reg, is2_f_reg, is1_c_reg, is2_c_reg;
   logic frozen_reg, taken_reg, tdis_reg, texc_reg;
   logic [`FCI_DATA_W-1:0] bus_reg;
   wire live    = decode_valid && !freeze && !trap_cycle_reg;
   wire f_inst  = live && !decode_is_cop && unit_op(decode_op);
   wire c_inst  = live && decode_is_cop && unit_op(decode_op);
   wire dis_trap = (f_inst && f_abs) || (c_inst && c_abs);
   wire f_exc_trap = f_inst && !f_abs && f_exc && !ack_f_reg;
   wire c_exc_trap = c_inst && !c_abs && c_exc && !ack_c_reg;
   wire any_trap = dis_trap || f_exc_trap || c_exc_trap;
   wire is_branch = (decode_op == fci_pkg::FCI_OP_BRANCH);
   wire [`FCI_CC_W-1:0] used_cc = decode_is_cop ? ccc2_reg : fcc2_reg;
   wire br_take = (f_inst || c_inst) && is_branch && !any_trap && (used_cc == branch_cond);
   wire issue   = (f_inst || c_inst) && !any_trap;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         is1_f_reg <= 1'b0;
         is2_f_reg <= 1'b0;
         is1_c_reg <= 1'b0;
         is2_c_reg <= 1'b0;
         trap_cycle_reg <= 1'b0;
         flush_reg <= 1'b0;
         fetch_reg <= 1'b0;
         bus_reg   <= '0;
         frozen_reg <= 1'b0;
         taken_reg <= 1'b0;
         tdis_reg  <= 1'b0;
         texc_reg  <= 1'b0;
      end else if (clk_en) begin
         // A single buffer select keeps the two strobes of a unit mutually exclusive.
         is1_f_reg <= issue && !decode_is_cop && !decode_in_buf_two;
         is2_f_reg <= issue && !decode_is_cop && decode_in_buf_two;
         is1_c_reg <= issue && decode_is_cop && !decode_in_buf_two;
         is2_c_reg <= issue && decode_is_cop && decode_in_buf_two;
         trap_cycle_reg <= any_trap;
         flush_reg <= any_trap;
         fetch_reg <= fetch_req && !freeze;
         if (fetch_req && !freeze) bus_reg <= fetch_word;
         frozen_reg <= freeze;
         taken_reg <= br_take;
         tdis_reg  <= dis_trap;
         texc_reg  <= f_exc_trap || c_exc_trap;
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_f_reg <= 1'b0;
         ack_c_reg <= 1'b0;
      end else if (clk_en) begin
         // Ack stays up until the synchronised request is seen low.
         if (f_exc_trap) ack_f_reg <= 1'b1;
         else if (!f_exc) ack_f_reg <= 1'b0;
         if (c_exc_trap) ack_c_reg <= 1'b1;
         else if (!c_exc) ack_c_reg <= 1'b0;
      end
   end
   assign port.float_issue_buf_one  = is1_f_reg;
   assign port.float_issue_buf_two  = is2_f_reg;
   assign port.coproc_issue_buf_one = is1_c_reg;
   assign port.coproc_issue_buf_two = is2_c_reg;
   assign port.float_exception_ack  = ack_f_reg;
   assign port.coproc_exception_ack = ack_c_reg;
   assign port.flush                = flush_reg;
   assign port.fetch_strobe         = fetch_reg;
   assign port.data_bus             = bus_reg;
   assign frozen         = frozen_reg;
   assign branch_taken   = taken_reg;
   assign trap_taken     = flush_reg;
   assign trap_disabled  = tdis_reg;
   assign trap_exception = texc_reg;
endmodule : fci_iu_end

// ### tb/fci_port_asserts.sv
// Checker for the coprocessor port pins between the two ends.
// Assumes the bench instantiates it beside the interface; one clock domain.
`timescale 1ns/100ps
module fci_port_asserts (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic float_codes_valid,
   input wire logic float_exception,
   input wire logic float_exception_ack,
   input wire logic float_issue_buf_one,
   input wire logic float_issue_buf_two,
   input wire logic coproc_codes_valid,
   input wire logic coproc_hold,
   input wire logic coproc_exception,
   input wire logic coproc_exception_ack,
   input wire logic coproc_issue_buf_one,
   input wire logic coproc_issue_buf_two,
   input wire logic flush
);
   wire logic any_issue = float_issue_buf_one | float_issue_buf_two | coproc_issue_buf_one | coproc_issue_buf_two;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   // Four cycles cover the two-flop input lag before the freeze takes hold.
   property p_fvalid_freeze; (!float_codes_valid) [*4] |=> !any_issue; endproperty
   a_fvalid_freeze: assert property (p_fvalid_freeze) else $error("issue with float codes invalid");
   property p_cvalid_freeze; (!coproc_codes_valid) [*4] |=> !any_issue; endproperty
   a_cvalid_freeze: assert property (p_cvalid_freeze) else $error("issue with coproc codes invalid");
   property p_coproc_hold_freeze; coproc_hold [*4] |=> !any_issue; endproperty
   a_coproc_hold_freeze: assert property (p_coproc_hold_freeze) else $error("issue under coproc hold");
   property p_fissue_excl; !(float_issue_buf_one && float_issue_buf_two); endproperty
   a_fissue_excl: assert property (p_fissue_excl) else $error("both float strobes");
   property p_cissue_excl; !(coproc_issue_buf_one && coproc_issue_buf_two); endproperty
   a_cissue_excl: assert property (p_cissue_excl) else $error("both coproc strobes");
   property p_fack_rise; $rose(float_exception_ack) |-> float_exception && (flush || $past(flush)); endproperty
   a_fack_rise: assert property (p_fack_rise) else $error("float ack without trap");
   property p_fack_fall; $fell(float_exception_ack) |-> !float_exception && !$past(float_exception); endproperty
   a_fack_fall: assert property (p_fack_fall) else $error("float ack dropped early");
   property p_cack_rise; $rose(coproc_exception_ack) |-> coproc_exception && (flush || $past(flush)); endproperty
   a_cack_rise: assert property (p_cack_rise) else $error("coproc ack without trap");
   c_fack: cover property (float_exception_ack);
   c_cack: cover property (coproc_exception_ack);
   c_freeze: cover property ((!float_codes_valid) [*4]);
endmodule : fci_port_asserts

// ### tb/test_fpu_coproc_interface.sv
// Bench joining both ends of the coprocessor port; coprocessor pins are driven here.
// Assumes the design files and fci_defines.svh are on the include path.
`timescale 1ns/100ps
`include "fci_defines.svh"
module test_fpu_coproc_interface;
   logic              ref_clk, reset_n, clk_en, fetch_req, decode_valid, decode_is_cop, decode_in_buf_two;
   logic              frozen, branch_taken, trap_taken, trap_disabled, trap_exception;
   logic              unit_fitted, raise_exception, queue_busy;
   logic [31:0]       fetch_word;
   logic [1:0]        branch_cond, compare_result;
   fci_pkg::fci_op_t  decode_op;
   int                fails, checked, i, u, ack_seen;
   fci_if fci_if_i();
   fci_iu_end fci_iu_end_i (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .port(fci_if_i.iu),
      .fetch_req(fetch_req), .fetch_word(fetch_word), .decode_valid(decode_valid), .decode_is_cop(decode_is_cop),
      .decode_in_buf_two(decode_in_buf_two), .decode_op(decode_op), .branch_cond(branch_cond), .frozen(frozen),
      .branch_taken(branch_taken), .trap_taken(trap_taken), .trap_disabled(trap_disabled),
      .trap_exception(trap_exception));
   fci_fpu_end fci_fpu_end_i (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .port(fci_if_i.fpu),
      .unit_fitted(unit_fitted), .raise_exception(raise_exception), .compare_result(compare_result),
      .queue_busy(queue_busy));
   fci_port_asserts fci_port_asserts_i (.ref_clk(ref_clk), .reset_n(reset_n),
      .float_codes_valid(fci_if_i.float_codes_valid), .float_exception(fci_if_i.float_exception),
      .float_exception_ack(fci_if_i.float_exception_ack), .float_issue_buf_one(fci_if_i.float_issue_buf_one),
      .float_issue_buf_two(fci_if_i.float_issue_buf_two), .coproc_codes_valid(fci_if_i.coproc_codes_valid),
      .coproc_hold(fci_if_i.coproc_hold), .coproc_exception(fci_if_i.coproc_exception),
      .coproc_exception_ack(fci_if_i.coproc_exception_ack), .coproc_issue_buf_one(fci_if_i.coproc_issue_buf_one),
      .coproc_issue_buf_two(fci_if_i.coproc_issue_buf_two), .flush(fci_if_i.flush));
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task stop_test;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test
   task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk
   function automatic logic sig(input int w);
      case (w)
         0: return frozen;
         1: return fci_if_i.float_exception;
         2: return fci_if_i.float_exception_ack;
         3: return fci_if_i.coproc_exception_ack;
         4: return fci_if_i.fetch_strobe;
         default: return queue_busy;
      endcase
   endfunction : sig
   task waitv(input int w, input logic v);
      for (int k = 0; k < 40 && sig(w) !== v; k++)
         @(negedge ref_clk);
      chk("wait", {31'h0, sig(w)}, {31'h0, v});
      if (sig(w) !== v)
         stop_test();
   endtask : waitv
   // The unit decodes the opcode from its own buffer, so each unit-side scenario fetches its word first.
   task fetch_one(input logic [31:0] w);
      fetch_word = w;
      fetch_req = 1'b1;
      @(negedge ref_clk);
      fetch_req = 1'b0;
      waitv(4, 1'b1);
      chk("data_bus", fci_if_i.data_bus, w);
   endtask : fetch_one
   // Counts pulses per nibble: flush, exc trap, disabled trap, branch, c2, c1, f2, f1.
   task issue(input logic cop, input logic b2, input fci_pkg::fci_op_t op, input logic [31:0] msk,
              input logic [31:0] exp);
      logic [31:0] seen;
      seen = 32'h0;
      ack_seen = 0;
      decode_is_cop = cop;
      decode_in_buf_two = b2;
      decode_op = op;
      decode_valid = 1'b1;
      @(negedge ref_clk);
      decode_valid = 1'b0;
      for (int k = 0; k < 6; k++) begin
         seen = seen + {3'h0, fci_if_i.flush, 3'h0, trap_exception, 3'h0, trap_disabled, 3'h0, branch_taken,
                        3'h0, fci_if_i.coproc_issue_buf_two, 3'h0, fci_if_i.coproc_issue_buf_one,
                        3'h0, fci_if_i.float_issue_buf_two, 3'h0, fci_if_i.float_issue_buf_one};
         ack_seen = ack_seen + fci_if_i.float_exception_ack + fci_if_i.coproc_exception_ack;
         @(negedge ref_clk);
      end
      chk("pulses", seen & msk, exp);
   endtask : issue
   initial begin
      {reset_n, fetch_req, decode_valid, decode_is_cop, decode_in_buf_two, raise_exception} = 6'h0;
      {clk_en, unit_fitted} = 2'h3;
      decode_op = fci_pkg::FCI_OP_NONE;
      {fetch_word, branch_cond, compare_result} = 36'h0;
      {fci_if_i.coproc_cond_codes, fci_if_i.coproc_exception, fci_if_i.coproc_hold} = 4'h0;
      {fci_if_i.coproc_codes_valid, fci_if_i.coproc_present_n} = 2'h2;
      {fails, checked} = 0;
      repeat (20) @(negedge ref_clk);
      reset_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk("frozen", {31'h0, frozen}, 32'h0);
      for (i = 0; i < 2; i++)
         fetch_one(32'hA5C3_0F10 + i);
      issue(1'b0, 1'b0, fci_pkg::FCI_OP_OPERATE, 32'hFFFF_FFFF, 32'h1);
      issue(1'b0, 1'b1, fci_pkg::FCI_OP_LDST, 32'hFFFF_FFFF, 32'h10);
      issue(1'b0, 1'b1, fci_pkg::FCI_OP_STSTATE, 32'hFFFF_FFFF, 32'h10);
      issue(1'b1, 1'b0, fci_pkg::FCI_OP_OPERATE, 32'hFFFF_FFFF, 32'h100);
      fci_if_i.coproc_cond_codes = 2'h2;
      branch_cond = 2'h2;
      // The codes pass two input flip-flops before the branch may use them.
      repeat (2) @(negedge ref_clk);
      issue(1'b1, 1'b1, fci_pkg::FCI_OP_BRANCH, 32'hFFFF_FFFF, 32'h1_1000);
      branch_cond = 2'h1;
      issue(1'b1, 1'b0, fci_pkg::FCI_OP_BRANCH, 32'hFFFF_FFFF, 32'h100);
      compare_result = 2'h1;
      fetch_one(32'h0000_0004);
      issue(1'b0, 1'b0, fci_pkg::FCI_OP_COMPARE, 32'hFFFF_FFFF, 32'h1);
      waitv(0, 1'b1);
      issue(1'b0, 1'b0, fci_pkg::FCI_OP_OPERATE, 32'hFFFF_FFFF, 32'h0);
      waitv(0, 1'b0);
      fetch_one(32'h0000_0001);
      issue(1'b0, 1'b0, fci_pkg::FCI_OP_BRANCH, 32'hFFFF_FFFF, 32'h1_0001);
      for (i = 0; i < 2; i++) begin
         fci_if_i.coproc_codes_valid = i[0];
         fci_if_i.coproc_hold = i[0];
         waitv(0, 1'b1);
         issue(1'b1, 1'b0, fci_pkg::FCI_OP_OPERATE, 32'hFFFF_FFFF, 32'h0);
         fci_if_i.coproc_codes_valid = 1'b1;
         fci_if_i.coproc_hold = 1'b0;
         waitv(0, 1'b0);
      end
      fci_if_i.coproc_present_n = 1'b1;
      unit_fitted = 1'b0;
      // The present pins pass through the two-flop input stage before they count.
      repeat (3) @(negedge ref_clk);
      for (u = 0; u < 2; u++)
         for (i = 1; i < 4; i++)
            issue(u[0], 1'b0, fci_pkg::fci_op_t'(i), 32'hFFF0_0000, 32'h1010_0000);
      fci_if_i.coproc_present_n = 1'b0;
      unit_fitted = 1'b1;
      repeat (3) @(negedge ref_clk);
      // A one-cycle event: a level held high would raise a fresh exception after each acknowledge.
      raise_exception = 1'b1;
      @(negedge ref_clk);
      raise_exception = 1'b0;
      waitv(1, 1'b1);
      issue(1'b1, 1'b0, fci_pkg::FCI_OP_OPERATE, 32'hFFFF_FFFF, 32'h100);
      issue(1'b0, 1'b0, fci_pkg::FCI_OP_OPERATE, 32'hFFF0_0000, 32'h1100_0000);
      chk("float_ack_cycles", ack_seen, 32'h4);
      waitv(2, 1'b0);
      chk("float_exception", {31'h0, fci_if_i.float_exception}, 32'h0);
      waitv(5, 1'b0);
      fci_if_i.coproc_hold = 1'b1;
      waitv(0, 1'b1);
      fci_if_i.coproc_exception = 1'b1;
      @(negedge ref_clk);
      fci_if_i.coproc_hold = 1'b0;
      waitv(0, 1'b0);
      issue(1'b0, 1'b0, fci_pkg::FCI_OP_OPERATE, 32'hFFFF_FFFF, 32'h1);
      issue(1'b1, 1'b0, fci_pkg::FCI_OP_LDST, 32'hFFF0_0000, 32'h1100_0000);
      waitv(3, 1'b1);
      fci_if_i.coproc_exception = 1'b0;
      waitv(3, 1'b0);
      stop_test();
   end
endmodule : test_fpu_coproc_interface
